// [fdd_regs.svh]
`ifndef FDD_REGS_SVH
`define FDD_REGS_SVH

// Register byte offsets on the AXI4-Lite slave.
`define FDD_CTRL_OFFSET       8'h00
`define FDD_STATUS_OFFSET     8'h04
`define FDD_SEEKINFO_OFFSET   8'h08

// Control register fields and reset value.
`define FDD_CTRL_ADDR_LSB     0
`define FDD_CTRL_ADDR_MSB     1
`define FDD_CTRL_RESET        32'h0000_0000

// Status register field positions.
`define FDD_ST_CYL_LSB        0
`define FDD_ST_CYL_MSB        9
`define FDD_ST_HEAD_LSB       10
`define FDD_ST_HEAD_MSB       13
`define FDD_ST_READY          16
`define FDD_ST_SEEKDONE       17
`define FDD_ST_HAZARD         18
`define FDD_ST_SELECTED       19
`define FDD_ST_SEEKING        20

// Clock rate and the timing figures in their own units.
`define FDD_CLK_MHZ           100
`define FDD_REV_PERIOD_US     16670
`define FDD_REV_LOW_NS        53400
`define FDD_READY_S           15
`define FDD_STEP_GAP_US       3100

// Seek time bands: upper length bound, base time and slope in us.
`define FDD_BAND1_MAX         1
`define FDD_BAND2_MAX         7
`define FDD_BAND3_MAX         31
`define FDD_BAND4_MAX         127
`define FDD_BAND5_MAX         511
`define FDD_BAND1_BASE_US     5000
`define FDD_BAND2_BASE_US     5000
`define FDD_BAND2_SLOPE_US    430
`define FDD_BAND3_BASE_US     8000
`define FDD_BAND3_SLOPE_US    220
`define FDD_BAND4_BASE_US     11000
`define FDD_BAND4_SLOPE_US    110
`define FDD_BAND5_BASE_US     15000
`define FDD_BAND5_SLOPE_US    53
`define FDD_BAND6_BASE_US     23000
`define FDD_BAND6_SLOPE_US    27

`endif

// [fdd_pkg.sv]
`default_nettype none
package fdd_pkg;
  // Head positioning states.
  typedef enum logic [1:0] {
    FDD_IDLE,
    FDD_SEEK
  } fdd_seek_state_t;
endpackage : fdd_pkg
`default_nettype wire

// [fdd_rev_mark.sv]
`timescale 1ns/1ps
`default_nettype none
// Revolution mark: LOW_CYCLES low at each PERIOD_CYCLES start.
module fdd_rev_mark #(
  parameter int unsigned PERIOD_CYCLES = 1667000,
  parameter int unsigned LOW_CYCLES    = 5340
) (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic running,
  output var  logic markLowReg
);
  logic [31:0] phaseReg;   // Position within the revolution.

  // Phase advances only while running.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      phaseReg <= 32'h0000_0000;
    end else if (!running || phaseReg == PERIOD_CYCLES - 1) begin
      phaseReg <= 32'h0000_0000;
    end else begin
      phaseReg <= phaseReg + 32'h0000_0001;
    end
  end

  // Low in the first part of the turn.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      markLowReg <= 1'b0;
    end else begin
      markLowReg <= running && (phaseReg < LOW_CYCLES - 1 ||
                                phaseReg == PERIOD_CYCLES - 1);
    end
  end
endmodule : fdd_rev_mark
`default_nettype wire

// [fdd_drive_ctrl.sv]
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "fdd_regs.svh"
// Contract
// [RQ1] Low-true head lines decode to head 0-15.
// [RQ2] Gate low writes, gate high reads.
// [RQ3] Each falling move pulse starts one cylinder.
// [RQ4] Host settles direction 100 ns before pulse.
// [RQ5] Host holds direction 100 ns after last pulse.
// [RQ6] Move pulses accumulate into a buffered seek.
// [RQ7] Host gaps between pulses stay under 3.1 ms.
// [RQ8] Seek time is banded by seek length.
// [RQ9] Direction high moves out, low moves in.
// [RQ10] Respond only while our unit select is low.
// [RQ11] Positioning done once settled on target cylinder.
// [RQ12] Outer-cylinder low exactly at cylinder zero.
// [RQ13] Hazard blocks writing until deselect or power cycle.
// [RQ14] Hazard on write current and gate mismatch.
// [RQ15] Hazard on bad head selection or off track.
// [RQ16] Host should edge detect the hazard line.
// [RQ17] Revolution mark low 53.4 us every 16.67 ms.
// [RQ18] Host uses only the mark's falling edge.
// [RQ19] Not ready blocks writing and seeking.
// [RQ20] Ready comes about 15 s after power-up.
// [RQ21] Low-true open-collector unit-selected output.
// [RQ22] Flux pairs are point to point, never shared.
// [RQ23] Positive write transition makes one flux reversal.
// [RQ24] Each detected reversal is a positive read transition.
// [RQ25] Refuse read, write and seek until ready.
// [RQ26] Up to four drives share four select lines.
// [RQ27] Positioning done drops on first pulse until settled.
// [RQ28] Count pulses by direction, never below cylinder zero.
module fdd_drive_ctrl #(
  parameter int unsigned CYLINDERS      = 918,
  parameter int unsigned CYCLES_PER_US  = `FDD_CLK_MHZ,
  parameter int unsigned REV_CYCLES     = `FDD_REV_PERIOD_US * `FDD_CLK_MHZ,
  parameter int unsigned REV_LOW_CYCLES = `FDD_REV_LOW_NS * `FDD_CLK_MHZ
                                          / 1000,
  parameter int unsigned STEP_GAP_CYCLES = `FDD_STEP_GAP_US * `FDD_CLK_MHZ,
  parameter int unsigned READY_CYCLES   = `FDD_READY_S * 1000000
                                          * `FDD_CLK_MHZ
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // AXI4-Lite register slave.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Shared control cable inputs, all low true.
  input  wire logic [3:0]  unitSelectN,
  input  wire logic [3:0]  head_number_lines,
  input  wire logic        writeGateN,
  input  wire logic        movePulseN,
  input  wire logic        directionInN,
  // Open-collector control outputs: level and enable.
  output var  logic        seekDoneOut,
  output var  logic        seekDoneOe,
  output var  logic        outerCylOut,
  output var  logic        outerCylOe,
  output var  logic        hazardOut,
  output var  logic        hazardOe,
  output var  logic        revMarkOut,
  output var  logic        revMarkOe,
  output var  logic        readyOut,
  output var  logic        readyOe,
  output var  logic        unitSelectedOut,
  output var  logic        unitSelectedOe,
  // Radial differential flux lines.
  input  wire logic        flux_write_pair_p,
  input  wire logic        flux_write_pair_n,
  output var  logic        flux_read_pair_p,
  output var  logic        flux_read_pair_n,
  // Head, write and actuator side of the drive.
  input  wire logic        spindleAtSpeed,
  input  wire logic        writeCurrentSense,
  input  wire logic        headSelectFault,
  input  wire logic        offTrack,
  input  wire logic        fluxDetected,
  output var  logic [3:0]  headSelect,
  output var  logic        writeEnable,
  output var  logic        fluxReversal,
  output var  logic [9:0]  cylinder
);
  logic [1:0]  unitAddrReg;       // Jumpered drive address.
  logic        selectedReg;       // Unit select matched last cycle.
  logic        readyReg;          // Spindle up and power-up wait over.
  logic [31:0] readyCountReg;     // Power-up wait counter.
  logic        hazardReg;         // Sticky write hazard.
  logic        movePrevReg;       // Move pulse level one cycle ago.
  logic        writePrevReg;      // Write pair polarity one cycle ago.
  logic [9:0]  targetReg;         // Cylinder the buffered seek aims at.
  logic [31:0] gapCountReg;       // Cycles since the last move pulse.
  logic [31:0] usDivReg;          // Microsecond prescaler.
  logic [31:0] elapsedUsReg;      // Time since the first move pulse.
  logic        markLow;           // Revolution mark from the timer.
  fdd_pkg::fdd_seek_state_t seekStateReg;

  logic        selectedNow;       // Our select line is low now.
  logic        moveEdge;          // Accepted falling move edge.
  logic        writeGateOn;       // Gate active and unit selected.
  logic        hazardSet;         // Any hazard condition now.
  logic [9:0]  seekLen;           // Cylinders between start and target.
  logic        seekOver;          // Buffered seek finished settling.

  // Seek time in us by length band.
  function automatic logic [31:0] seek_us(input logic [9:0] len);
    logic [31:0] l;
    l = {22'h000000, len};
    if (l <= `FDD_BAND1_MAX) begin
      seek_us = `FDD_BAND1_BASE_US;
    end else if (l <= `FDD_BAND2_MAX) begin
      seek_us = `FDD_BAND2_BASE_US + `FDD_BAND2_SLOPE_US * l;
    end else if (l <= `FDD_BAND3_MAX) begin
      seek_us = `FDD_BAND3_BASE_US + `FDD_BAND3_SLOPE_US * l;
    end else if (l <= `FDD_BAND4_MAX) begin
      seek_us = `FDD_BAND4_BASE_US + `FDD_BAND4_SLOPE_US * l;
    end else if (l <= `FDD_BAND5_MAX) begin
      seek_us = `FDD_BAND5_BASE_US + `FDD_BAND5_SLOPE_US * l;
    end else begin
      seek_us = `FDD_BAND6_BASE_US + `FDD_BAND6_SLOPE_US * l;
    end
  endfunction : seek_us

  // Only our jumpered select line connects us.
  assign selectedNow = !unitSelectN[unitAddrReg]; // see [RQ10] [RQ26]
  // A move edge counts only while selected and ready.
  assign moveEdge = selectedNow && readyReg && movePrevReg &&
                    !movePulseN; // see [RQ3] [RQ19] [RQ25]
  assign writeGateOn = selectedNow && !writeGateN; // see [RQ2]
  // Current must match gate; head and track sound.
  assign hazardSet = selectedNow &&
                     ((writeCurrentSense && writeGateN) ||
                      (!writeCurrentSense && !writeGateN) ||
                      headSelectFault || offTrack); // see [RQ14] [RQ15]
  assign seekLen = (targetReg >= cylinder) ? targetReg - cylinder
                                           : cylinder - targetReg;
  // Quiet gap and band time both over.
  assign seekOver = gapCountReg >= STEP_GAP_CYCLES &&
                    elapsedUsReg >= seek_us(seekLen); // see [RQ8] [RQ7]

  // The mark runs only while ready.
  fdd_rev_mark #(
    .PERIOD_CYCLES (REV_CYCLES),
    .LOW_CYCLES    (REV_LOW_CYCLES)
  ) u_rev_mark (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .running    (readyReg),
    .markLowReg (markLow)
  ); // see [RQ17]

  // Selection state for the hazard's deselect clear.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      selectedReg <= 1'b0;
    end else begin
      selectedReg <= selectedNow;
    end
  end

  // Power-up wait before ready.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      readyCountReg <= 32'h0000_0000;
      readyReg      <= 1'b0;
    end else if (!spindleAtSpeed) begin
      // Losing speed drops ready and restarts the wait.
      readyCountReg <= 32'h0000_0000;
      readyReg      <= 1'b0;
    end else if (readyCountReg < READY_CYCLES - 1) begin
      readyCountReg <= readyCountReg + 32'h0000_0001;
    end else begin
      readyReg      <= 1'b1; // see [RQ20]
    end
  end

  // Sticky hazard: causes count only while selected, so the deselect cycle always clears.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      hazardReg <= 1'b0;
    end else if (hazardSet) begin
      hazardReg <= 1'b1; // see [RQ13]
    end else if (selectedReg && !selectedNow) begin
      hazardReg <= 1'b0; // see [RQ13]
    end
  end

  // Edge history for the move pulse and the write pair.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      movePrevReg  <= 1'b1;
      writePrevReg <= 1'b0;
    end else begin
      movePrevReg  <= movePulseN;
      writePrevReg <= flux_write_pair_p && !flux_write_pair_n;
    end
  end

  // Buffered seek: collect pulses, wait out the band.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      seekStateReg <= fdd_pkg::FDD_IDLE;
      targetReg    <= 10'h000;
      cylinder     <= 10'h000;
      gapCountReg  <= 32'h0000_0000;
      usDivReg     <= 32'h0000_0000;
      elapsedUsReg <= 32'h0000_0000;
    end else begin
      if (moveEdge) begin
        // Direction is sampled at the edge; out stops at zero.
        if (!directionInN) begin
          if (targetReg < 10'(CYLINDERS - 1)) begin
            targetReg <= targetReg + 10'h001; // see [RQ9] [RQ28]
          end
        end else if (targetReg != 10'h000) begin
          targetReg <= targetReg - 10'h001; // see [RQ9] [RQ28]
        end
        gapCountReg <= 32'h0000_0000; // see [RQ6]
      end else if (gapCountReg < STEP_GAP_CYCLES) begin
        gapCountReg <= gapCountReg + 32'h0000_0001;
      end
      unique case (seekStateReg)
        fdd_pkg::FDD_IDLE: begin
          usDivReg     <= 32'h0000_0000;
          elapsedUsReg <= 32'h0000_0000;
          if (moveEdge) begin
            // The first pulse starts the seek clock.
            seekStateReg <= fdd_pkg::FDD_SEEK; // see [RQ27]
          end
        end
        fdd_pkg::FDD_SEEK: begin
          if (usDivReg == CYCLES_PER_US - 1) begin
            usDivReg     <= 32'h0000_0000;
            elapsedUsReg <= elapsedUsReg + 32'h0000_0001;
          end else begin
            usDivReg <= usDivReg + 32'h0000_0001;
          end
          if (seekOver && !moveEdge) begin
            cylinder     <= targetReg; // see [RQ11]
            seekStateReg <= fdd_pkg::FDD_IDLE;
          end
        end
      endcase
    end
  end

  // Head choice and the write and read data paths.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      headSelect       <= 4'h0;
      writeEnable      <= 1'b0;
      fluxReversal     <= 1'b0;
      flux_read_pair_p <= 1'b0;
      flux_read_pair_n <= 1'b1;
    end else begin
      if (selectedNow) begin
        headSelect <= ~head_number_lines; // see [RQ1]
      end
      // Writing needs gate, ready, settled heads and no hazard.
      writeEnable <= writeGateOn && readyReg && !hazardReg && !hazardSet &&
                     seekStateReg == fdd_pkg::FDD_IDLE; // see [RQ13] [RQ19]
      // One reversal per positive-going write pair transition.
      fluxReversal <= writeEnable && !writePrevReg &&
                      flux_write_pair_p && !flux_write_pair_n; // see [RQ23]
      // Each detected reversal: one-cycle positive pulse.
      flux_read_pair_p <= fluxDetected && readyReg && selectedNow &&
                          writeGateN; // see [RQ24] [RQ2] [RQ22]
      flux_read_pair_n <= !(fluxDetected && readyReg && selectedNow &&
                            writeGateN);
    end
  end

  // Open-collector lines pull low only while selected.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      seekDoneOut     <= 1'b0;
      seekDoneOe      <= 1'b0;
      outerCylOut     <= 1'b0;
      outerCylOe      <= 1'b0;
      hazardOut       <= 1'b0;
      hazardOe        <= 1'b0;
      revMarkOut      <= 1'b0;
      revMarkOe       <= 1'b0;
      readyOut        <= 1'b0;
      readyOe         <= 1'b0;
      unitSelectedOut <= 1'b0;
      unitSelectedOe  <= 1'b0;
    end else begin
      seekDoneOe     <= selectedNow && seekStateReg == fdd_pkg::FDD_IDLE
                        && !moveEdge; // see [RQ11] [RQ27] [RQ10]
      outerCylOe     <= selectedNow && cylinder == 10'h000; // see [RQ12]
      hazardOe       <= selectedNow && (hazardReg || hazardSet);
      revMarkOe      <= selectedNow && markLow; // see [RQ17]
      readyOe        <= selectedNow && readyReg; // see [RQ19]
      unitSelectedOe <= selectedNow; // see [RQ21]
    end
  end

  // AXI4-Lite write channel: address and data in either order.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      unitAddrReg   <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
      end
      // Both halves held: perform the write and answer once.
      if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        if (s_axi_awaddr == `FDD_CTRL_OFFSET) begin
          s_axi_bresp <= 2'h0;
          if (s_axi_wstrb[0]) begin
            unitAddrReg <= s_axi_wdata[`FDD_CTRL_ADDR_MSB:
                                       `FDD_CTRL_ADDR_LSB];
          end
        end else if (s_axi_awaddr == `FDD_STATUS_OFFSET ||
                     s_axi_awaddr == `FDD_SEEKINFO_OFFSET) begin
          // Read-only registers ignore the write.
          s_axi_bresp <= 2'h0;
        end else begin
          s_axi_bresp <= 2'h2;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channel: one cycle from address to data.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= 32'h0000_0000;
        s_axi_rresp   <= 2'h0;
        unique case (s_axi_araddr)
          `FDD_CTRL_OFFSET: begin
            s_axi_rdata[`FDD_CTRL_ADDR_MSB:`FDD_CTRL_ADDR_LSB] <= unitAddrReg;
          end
          `FDD_STATUS_OFFSET: begin
            s_axi_rdata[`FDD_ST_CYL_MSB:`FDD_ST_CYL_LSB]   <= cylinder;
            s_axi_rdata[`FDD_ST_HEAD_MSB:`FDD_ST_HEAD_LSB] <= headSelect;
            s_axi_rdata[`FDD_ST_READY]    <= readyReg;
            s_axi_rdata[`FDD_ST_SEEKDONE] <= seekStateReg ==
                                             fdd_pkg::FDD_IDLE;
            s_axi_rdata[`FDD_ST_HAZARD]   <= hazardReg;
            s_axi_rdata[`FDD_ST_SELECTED] <= selectedReg;
            s_axi_rdata[`FDD_ST_SEEKING]  <= seekStateReg ==
                                             fdd_pkg::FDD_SEEK;
          end
          `FDD_SEEKINFO_OFFSET: begin
            // Target in the low half, elapsed microseconds above it.
            s_axi_rdata <= {elapsedUsReg[15:0], 6'h00, targetReg};
          end
          default: begin
            s_axi_rresp <= 2'h2;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule : fdd_drive_ctrl
`default_nettype wire

// [fdd_drive_ctrl_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
// Cable outputs against their causes; one clock domain.
module fdd_drive_ctrl_asserts (
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic [3:0] head_number_lines,
  input wire logic       writeGateN,
  input wire logic       movePulseN,
  input wire logic       seekDoneOe,
  input wire logic       outerCylOe,
  input wire logic       hazardOe,
  input wire logic       revMarkOe,
  input wire logic       readyOe,
  input wire logic       unitSelectedOe,
  input wire logic       flux_read_pair_p,
  input wire logic       flux_read_pair_n,
  input wire logic [3:0] headSelect,
  input wire logic       writeEnable,
  input wire logic [9:0] cylinder
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  // The longest seek outgrows a delay range, so a counter bounds it.
  int busyCnt; // Cycles with done released while selected.
  always_ff @(posedge sys_clk)
    busyCnt <= (seekDoneOe || !unitSelectedOe) ? 0 : busyCnt + 1;
  AST_HEAD_DECODE: assert property (
    unitSelectedOe |-> headSelect == ~$past(head_number_lines))
    else $error("bad head");
  AST_DESEL_QUIET: assert property (
    !unitSelectedOe |-> !(seekDoneOe | outerCylOe | hazardOe
                          | readyOe | revMarkOe))
    else $error("driven deselected");
  AST_OUTER_CYL: assert property (
    (unitSelectedOe && $stable(cylinder)) [*2]
      |-> outerCylOe == (cylinder == 10'h000))
    else $error("bad outer");
  AST_STEP_DROPS_DONE: assert property (
    $fell(movePulseN) && unitSelectedOe && readyOe |=> !seekDoneOe)
    else $error("done kept");
  AST_SEEK_BOUNDED: assert property (
    $fell(seekDoneOe) && unitSelectedOe |-> !seekDoneOe [*8])
    else $error("seek too short");
  AST_SEEK_LIMIT: assert property (busyCnt < 4800000)
    else $error("seek too long");
  AST_CYL_IN_SEEK: assert property (
    $changed(cylinder) |-> !seekDoneOe)
    else $error("cyl moved");
  AST_WRITE_BLOCKED: assert property (
    writeEnable |-> $past(!writeGateN && !hazardOe))
    else $error("bad write");
  AST_READ_PULSE: assert property (
    $rose(flux_read_pair_p) |-> !flux_read_pair_n
      ##1 !flux_read_pair_p && flux_read_pair_n)
    else $error("bad read pulse");
  // Main scenarios.
  COV_SEEK: cover property ($fell(seekDoneOe));
  COV_HAZARD: cover property ($rose(hazardOe));
  COV_READ: cover property ($rose(flux_read_pair_p));
endmodule : fdd_drive_ctrl_asserts
bind fdd_drive_ctrl fdd_drive_ctrl_asserts u_chk (.*);
`default_nettype wire

// [fdd_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Host side of the cable.
module fdd_host_model (
  input  wire logic sys_clk,
  output var  logic movePulseN,
  output var  logic directionInN,
  output var  logic flux_write_pair_p,
  output var  logic flux_write_pair_n
);
  // Idle: no step, direction out, write pair inactive.
  initial begin
    {movePulseN, directionInN} = 2'b11;
    {flux_write_pair_p, flux_write_pair_n} = 2'b01;
  end
  // Steps spaced sp+1 cycles apart, under the gap.
  task automatic seek(input int n, input logic inw, input int sp);
    @(posedge sys_clk) directionInN <= ~inw;
    repeat (12) @(posedge sys_clk);
    for (int i = 0; i < n; i++) begin
      movePulseN <= 1'b0;
      @(posedge sys_clk) movePulseN <= 1'b1;
      repeat (sp) @(posedge sys_clk);
    end
    repeat (12) @(posedge sys_clk);
  endtask : seek
  // One positive transition on the write pair.
  task automatic pulse();
    @(posedge sys_clk) {flux_write_pair_p, flux_write_pair_n} <= 2'b10;
    @(posedge sys_clk) {flux_write_pair_p, flux_write_pair_n} <= 2'b01;
  endtask : pulse
endmodule : fdd_host_model
`default_nettype wire

// [tb_fixed_disk_drive_control_interface.sv]
`timescale 1ns/1ps
`default_nettype none
// Cable and register bus stimulus.
module tb_fixed_disk_drive_control_interface;
  // Timing shortened so that a run stays brief.
  localparam int READY = 50, REV = 200, LOW = 10, GAP = 20;
  typedef struct packed {
    logic [3:0] hd;
    logic inw;
    int n;
    int sp;
    logic [9:0] cyl;
  } fdd_row_t;
  // Head, direction, steps, spacing, target cylinder.
  fdd_row_t rows [4] = '{'{4'h3, 1'b1, 5, 3, 10'h005},
    '{4'hf, 1'b1, 3, 15, 10'h008}, '{4'h0, 1'b0, 2, 3, 10'h006},
    '{4'h9, 1'b0, 10, 3, 10'h000}};
  logic sys_clk = 1'b0, reset = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_rvalid;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [3:0] unitSelectN = 4'hf, head_number_lines = 4'hf;
  logic writeGateN = 1'b1, spindleAtSpeed = 1'b0, fluxDetected = 1'b0;
  logic wrCur = 1'b0, writeCurrentSense, headSelectFault, offTrack;
  logic [2:0] fault = 3'h0; // Injected write hazard causes.
  logic movePulseN, directionInN, flux_write_pair_p, flux_write_pair_n;
  logic seekDoneOut, seekDoneOe, outerCylOut, outerCylOe, hazardOut;
  logic hazardOe, revMarkOut, revMarkOe, readyOut, readyOe;
  logic unitSelectedOut, unitSelectedOe, flux_read_pair_p;
  logic flux_read_pair_n, writeEnable, fluxReversal;
  logic [3:0] headSelect;
  logic [9:0] cylinder;
  logic [31:0] d;
  int failures = 0, samples_checked = 0, n, frCnt = 0, rdCnt = 0;
  assign writeCurrentSense = fault[0] | wrCur;
  assign {offTrack, headSelectFault} = fault[2:1];
  always #5 sys_clk = ~sys_clk;
  // Pulse counters for exact counts.
  always @(posedge sys_clk) begin
    frCnt += int'(fluxReversal);
    rdCnt += int'(flux_read_pair_p);
  end
  fdd_drive_ctrl #(.CYCLES_PER_US(1), .REV_CYCLES(REV),
    .REV_LOW_CYCLES(LOW), .STEP_GAP_CYCLES(GAP), .READY_CYCLES(READY))
    dut (.*);
  fdd_host_model host (.*);
  function automatic int band(input int l);
    if (l <= 1) return 5000;
    if (l <= 7) return 5000 + 430 * l;
    return 8000 + 220 * l;
  endfunction : band
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  // Bus write; each channel is released on its own handshake.
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    {s_axi_awaddr, s_axi_wdata} <= {a, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask : axr
  task automatic conclude();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude
  // Watchdog well past the longest run.
  initial begin
    repeat (60000) @(posedge sys_clk);
    failures++;
    conclude();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    axr(8'h00);
    chk(d, 32'h0);
    axr(8'h0c);
    chk(r, 2'h2);
    axw(8'h0c, 32'h1);
    chk(r, 2'h2);
    axw(8'h00, 32'h2);
    unitSelectN <= 4'hb;
    host.seek(1, 1'b1, 3);
    axr(8'h04);
    chk({unitSelectedOe, readyOe, d[20]}, 3'b100);
    spindleAtSpeed <= 1'b1;
    repeat (READY - 2) @(posedge sys_clk);
    chk(readyOe, 1'b0);
    repeat (6) @(posedge sys_clk);
    chk(readyOe, 1'b1);
    // Timed from falling edges; the first mark may be cut short.
    while (revMarkOe === 1'b1) @(posedge sys_clk);
    while (revMarkOe !== 1'b1) @(posedge sys_clk);
    for (n = 0; revMarkOe === 1'b1; n++) @(posedge sys_clk);
    chk(n, LOW);
    for (; revMarkOe !== 1'b1; n++) @(posedge sys_clk);
    chk(n, REV);
    foreach (rows[i]) begin
      head_number_lines <= ~rows[i].hd;
      fork
        host.seek(rows[i].n, rows[i].inw, rows[i].sp);
      join_none
      while (movePulseN !== 1'b0) @(posedge sys_clk);
      for (n = 0; seekDoneOe !== 1'b1 || n < 2; n++) @(posedge sys_clk);
      wait fork;
      d = (i == 0) ? 0 : rows[i - 1].cyl;
      d = (d > rows[i].cyl) ? d - rows[i].cyl : rows[i].cyl - d;
      chk(n >= band(d) && n < band(d) + 200, 1'b1);
      chk(cylinder, rows[i].cyl);
      chk(outerCylOe, rows[i].cyl == 0);
      chk(headSelect, rows[i].hd);
    end
    {writeGateN, wrCur} <= 2'b01;
    repeat (3) @(posedge sys_clk);
    chk(writeEnable, 1'b1);
    n = frCnt;
    host.pulse();
    repeat (4) @(posedge sys_clk);
    chk(frCnt - n, 1);
    {writeGateN, wrCur} <= 2'b10;
    n = rdCnt;
    fluxDetected <= 1'b1;
    @(posedge sys_clk) fluxDetected <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk(rdCnt - n, 1);
    // Each cause latches the hazard until deselect.
    for (int k = 0; k < 3; k++) begin
      fault <= 3'h1 << k;
      repeat (3) @(posedge sys_clk);
      fault <= 3'h0;
      {writeGateN, wrCur} <= 2'b01;
      repeat (3) @(posedge sys_clk);
      chk({hazardOe, writeEnable}, 2'b10);
      {writeGateN, wrCur} <= 2'b10;
      unitSelectN <= 4'hf;
      host.seek(1, 1'b1, 3);
      chk({seekDoneOe, hazardOe, readyOe}, 3'b000);
      unitSelectN <= 4'hb;
      repeat (3) @(posedge sys_clk);
      chk({seekDoneOe, hazardOe}, 2'b10);
    end
    conclude();
  end
endmodule : tb_fixed_disk_drive_control_interface
`default_nettype wire
